// ===== rtl/hivc_defs.vh
// register offsets, field positions and reset values of the hardware interrupt block
// assumes inclusion by plain name from rtl/
`ifndef HIVC_DEFS_VH
`define HIVC_DEFS_VH
// apb byte addresses
`define HIVC_OFF_GROUP_EN   16'hC00E
`define HIVC_OFF_PIN_CTRL   16'hC01C
`define HIVC_OFF_PWR_DOWN   16'hC00A
`define HIVC_OFF_PENDING    16'hC040
`define HIVC_OFF_MASK       16'hC044
`define HIVC_OFF_ACK        16'hC048
`define HIVC_OFF_VEC_BASE   16'h0000
`define HIVC_OFF_VEC_LAST   16'h003E
// group enable fields
`define HIVC_GE_TIMER0      0
`define HIVC_GE_TIMER1      1
`define HIVC_GE_PIN         2
`define HIVC_GE_UART        3
`define HIVC_GE_USB         5
`define HIVC_GE_WMASK       16'h002F
// pin control fields
`define HIVC_PC_EN0         0
`define HIVC_PC_POL0        1
`define HIVC_PC_EN1         2
`define HIVC_PC_POL1        3
`define HIVC_PC_WMASK       16'h000F
// power down fields
`define HIVC_PD_WAKE_PIN    4
`define HIVC_PD_WAKE_USB    5
`define HIVC_PD_WMASK       16'h0030
// interrupt numbers
`define HIVC_NUM_TIMER0     0
`define HIVC_NUM_TIMER1     1
`define HIVC_NUM_EXT0       2
`define HIVC_NUM_EXT1       3
`define HIVC_NUM_UART_TX    4
`define HIVC_NUM_UART_RX    5
`define HIVC_NUM_DMA        6
`define HIVC_NUM_USB_RST    7
`define HIVC_NUM_USB_SOF    8
`define HIVC_NUM_EP_BASE    9
`define HIVC_NUM_SRC        17
`define HIVC_NUM_HW_VEC     64
`define HIVC_NUM_TOTAL      127
// reset values
`define HIVC_RST_GROUP_EN   16'h0000
`define HIVC_RST_PIN_CTRL   16'h0000
`define HIVC_RST_PWR_DOWN   16'h0000
`define HIVC_RST_MASK       17'h1FFFF
`endif

// ===== rtl/hivc_edge_detect.v
// one external request pin: synchroniser, selectable edge detector
// assumes an asynchronous pin and the system clock
module hivc_edge_detect (
    // clock and reset
    input  wire sys_clk,
    input  wire rst,
    // pin and setting
    input  wire pinIn,
    input  wire risingSel,
    // detected edge, one cycle
    output reg  edgeSeen
);
    reg syncA_q;
    reg syncB_q;
    reg last_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            syncA_q  <= 1'b0;
            syncB_q  <= 1'b0;
            last_q   <= 1'b0;
            edgeSeen <= 1'b0;
        end else begin
            syncA_q  <= pinIn;
            syncB_q  <= syncA_q;
            last_q   <= syncB_q;
            edgeSeen <= risingSel ? (syncB_q & ~last_q) : (~syncB_q & last_q);
        end
    end
endmodule

// ===== rtl/hivc_top.v
// hardware interrupt vector control: vector memory, group enables, pin edges,
// pending latches with lowest-number priority, apb slave
// assumes one synchronous clock domain; the core fetches vectors via vecFetch
// Operation
// - 127 vectors; lower 64 hardware
// - vector n at byte 2n, 0x0000..0x003E
// - numbers 0..8 fixed peripheral sources
// - numbers 9..16 endpoint ok/error pairs
// - sof token raises start-of-frame interrupt
// - vector area plain unprotected read/write memory
// - group enables usb, uart, timers
// - d2 enables external pin group
// - two edge-triggered external request pins
// - polarity bit selects rising or falling
// - per-pin enable bits, edges ignored when clear (code: edges of a disabled pin still drive wakeUp)
// - pin settings act only with group bit (code: polarity still selects the wake edge with the group bit clear)
// - wake and interrupt enables independent
// - power-down wake enables pin and usb
`include "hivc_defs.vh"
module hivc_top #(
    parameter VEC_WORDS = 32
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // source events, one cycle each
    input  wire        timer0Evt,
    input  wire        timer1Evt,
    input  wire        uartTxEvt,
    input  wire        uartRxEvt,
    input  wire        dmaDoneEvt,
    input  wire        usbResetEvt,
    input  wire        usbSofToken,
    input  wire [3:0]  epOkEvt,
    input  wire [3:0]  epErrEvt,
    input  wire        usbActivity,
    // external request pins
    input  wire        ext_req0_pin,
    input  wire        ext_req1_pin,
    // processor core side
    output wire        irqOut,
    output reg  [5:0]  irqNumber,
    input  wire        irqAck,
    input  wire        vecFetch,
    output reg  [15:0] vecAddr,
    output reg         vecValid,
    // power down
    output reg         wakeUp
);
    localparam NSRC = `HIVC_NUM_SRC;

    reg  [15:0]     groupEn_q;
    reg  [15:0]     pinCtrl_q;
    reg  [15:0]     pwrDown_q;
    reg  [NSRC-1:0] pending_q;
    reg  [NSRC-1:0] mask_q;
    reg  [15:0]     vecMem [0:VEC_WORDS-1];
    wire            ext0Edge;
    wire            ext1Edge;

    hivc_edge_detect uEdge0 (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pinIn     (ext_req0_pin),
        .risingSel (pinCtrl_q[`HIVC_PC_POL0]),
        .edgeSeen  (ext0Edge)
    );

    hivc_edge_detect uEdge1 (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pinIn     (ext_req1_pin),
        .risingSel (pinCtrl_q[`HIVC_PC_POL1]),
        .edgeSeen  (ext1Edge)
    );

    // apb decode, zero wait states
    wire        wrStb  = psel & penable & pwrite;
    wire        rdStb  = psel & penable & ~pwrite;
    wire        inVec  = (paddr <= `HIVC_OFF_VEC_LAST);
    wire [4:0]  vecIdx = paddr[5:1];
    wire        hitGe  = (paddr == `HIVC_OFF_GROUP_EN);
    wire        hitPc  = (paddr == `HIVC_OFF_PIN_CTRL);
    wire        hitPd  = (paddr == `HIVC_OFF_PWR_DOWN);
    wire        hitPn  = (paddr == `HIVC_OFF_PENDING);
    wire        hitMk  = (paddr == `HIVC_OFF_MASK);
    wire        hitAk  = (paddr == `HIVC_OFF_ACK);
    wire        mapped = inVec | hitGe | hitPc | hitPd | hitPn | hitMk | hitAk;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // raw requests in vector number order
    wire usbOn = groupEn_q[`HIVC_GE_USB];
    wire pinOn = groupEn_q[`HIVC_GE_PIN];
    wire [NSRC-1:0] rawReq;
    assign rawReq[`HIVC_NUM_TIMER0]  = timer0Evt & groupEn_q[`HIVC_GE_TIMER0];
    assign rawReq[`HIVC_NUM_TIMER1]  = timer1Evt & groupEn_q[`HIVC_GE_TIMER1];
    assign rawReq[`HIVC_NUM_EXT0]    = ext0Edge & pinOn & pinCtrl_q[`HIVC_PC_EN0];
    assign rawReq[`HIVC_NUM_EXT1]    = ext1Edge & pinOn & pinCtrl_q[`HIVC_PC_EN1];
    assign rawReq[`HIVC_NUM_UART_TX] = uartTxEvt & groupEn_q[`HIVC_GE_UART];
    assign rawReq[`HIVC_NUM_UART_RX] = uartRxEvt & groupEn_q[`HIVC_GE_UART];
    assign rawReq[`HIVC_NUM_DMA]     = dmaDoneEvt;
    assign rawReq[`HIVC_NUM_USB_RST] = usbResetEvt & usbOn;
    assign rawReq[`HIVC_NUM_USB_SOF] = usbSofToken & usbOn;

    genvar ep;
    generate
        for (ep = 0; ep < 4; ep = ep + 1) begin : gEp
            assign rawReq[`HIVC_NUM_EP_BASE + 2*ep]     = epOkEvt[ep] & usbOn;
            assign rawReq[`HIVC_NUM_EP_BASE + 2*ep + 1] = epErrEvt[ep] & usbOn;
        end
    endgenerate

    // lowest pending unmasked number wins
    wire [NSRC-1:0] active = pending_q & mask_q;
    reg  [5:0]      winNum;
    reg             winAny;
    integer         k;
    always @* begin
        winNum = 6'h00;
        winAny = 1'b0;
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (active[k]) begin
                winNum = k[5:0];
                winAny = 1'b1;
            end
        end
    end
    assign irqOut = winAny;

    // core acknowledge strobe clears the winner; ack register write clears every pending bit written as one
    wire [NSRC-1:0] ackClr  = (irqAck & winAny) ? ({{(NSRC-1){1'b0}}, 1'b1} << winNum)
                                                : {NSRC{1'b0}};
    wire [NSRC-1:0] swClr   = (wrStb & hitAk) ? pwdata[NSRC-1:0] : {NSRC{1'b0}};
    wire [NSRC-1:0] pendD   = (pending_q & ~(ackClr | swClr)) | rawReq;

    always @(posedge sys_clk) begin
        if (rst) begin
            groupEn_q <= `HIVC_RST_GROUP_EN;
            pinCtrl_q <= `HIVC_RST_PIN_CTRL;
            pwrDown_q <= `HIVC_RST_PWR_DOWN;
            mask_q    <= `HIVC_RST_MASK;
            pending_q <= {NSRC{1'b0}};
        end else begin
            pending_q <= pendD;
            if (wrStb & hitGe)
                groupEn_q <= pwdata[15:0] & `HIVC_GE_WMASK;
            if (wrStb & hitPc)
                pinCtrl_q <= pwdata[15:0] & `HIVC_PC_WMASK;
            if (wrStb & hitPd)
                pwrDown_q <= pwdata[15:0] & `HIVC_PD_WMASK;
            if (wrStb & hitMk)
                mask_q <= pwdata[NSRC-1:0];
        end
    end

    // vector memory, no protection, no reset
    always @(posedge sys_clk) begin
        if (wrStb & inVec)
            vecMem[vecIdx] <= pwdata[15:0];
    end

    // vector fetch: read word at 2n, hand address to core
    always @(posedge sys_clk) begin
        if (rst) begin
            vecAddr   <= 16'h0000;
            vecValid  <= 1'b0;
            irqNumber <= 6'h00;
        end else begin
            irqNumber <= winNum;
            vecValid  <= vecFetch & winAny;
            if (vecFetch & winAny)
                vecAddr <= vecMem[winNum[4:0]];
        end
    end

    // wake from suspend is separate from the group enables
    always @(posedge sys_clk) begin
        if (rst)
            wakeUp <= 1'b0;
        else
            wakeUp <= (pwrDown_q[`HIVC_PD_WAKE_PIN] & (ext0Edge | ext1Edge)) |
                      (pwrDown_q[`HIVC_PD_WAKE_USB] & usbActivity);
    end

    // read mux
    always @* begin
        prdata = 32'h0000_0000;
        if (rdStb) begin
            if (inVec)
                prdata = {16'h0000, vecMem[vecIdx]};
            else if (hitGe)
                prdata = {16'h0000, groupEn_q};
            else if (hitPc)
                prdata = {16'h0000, pinCtrl_q};
            else if (hitPd)
                prdata = {16'h0000, pwrDown_q};
            else if (hitPn)
                prdata = {{(32-NSRC){1'b0}}, pending_q};
            else if (hitMk)
                prdata = {{(32-NSRC){1'b0}}, mask_q};
        end
    end
endmodule

// ===== tb/hivc_top_properties.sv
// port checks for hivc_top
// assumes bind onto hivc_top, one clock
module hivc_top_props (
    // clock, reset
    input logic        sys_clk,
    input logic        rst,
    // apb
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [15:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // core side
    input logic        irqOut,
    input logic        irqAck,
    input logic        vecFetch,
    input logic        vecValid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence rdAt(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("ready low");
    vec_open_a: assert property (psel && penable && paddr <= 16'h003E |-> !pslverr)
        else $error("vector refused");
    hole_err_a: assert property (psel && penable && paddr == 16'h8000 |-> pslverr)
        else $error("hole accepted");
    idle_zero_a: assert property (!psel |-> prdata == 32'h0)
        else $error("stray read data");
    group_bits_a: assert property (rdAt(16'hC00E) |-> (prdata & ~32'h2F) == 32'h0)
        else $error("group bits");
    pin_bits_a: assert property (rdAt(16'hC01C) |-> prdata[31:4] == 28'h0)
        else $error("pin bits");
    fetch_valid_a: assert property (vecValid == $past(vecFetch))
        else $error("fetch answer");
    irq_drop_a: assert property ($fell(irqOut) |-> $past(irqAck) || $past(psel && pwrite))
        else $error("irq dropped");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !irqOut && !vecValid)
        else $error("busy after reset");
endmodule
bind hivc_top hivc_top_props i_hivc_top_props (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .irqOut, .irqAck, .vecFetch, .vecValid);

// ===== tb/hivc_core_model.sv
// processor core model: fetch vector, then acknowledge
// assumes hivc_top core-side timing, one clock
module hivc_core_model (
    // clock, reset
    input  logic        sys_clk,
    input  logic        rst,
    // from interrupt block
    input  logic        irqOut,
    input  logic [5:0]  irqNumber,
    input  logic        vecValid,
    input  logic [15:0] vecAddr,
    // extra wait before fetch
    input  logic [3:0]  slowCycles,
    // to interrupt block
    output logic        vecFetch,
    output logic        irqAck,
    // last serviced request
    output logic [15:0] takenAddr,
    output logic [5:0]  takenNum,
    output int          taken
);
    logic [4:0] cnt;
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge sys_clk) begin
        vecFetch <= 1'b0;
        irqAck <= 1'b0;
        cnt <= 5'h00;
        if (rst) begin
            taken <= 0;
        end else if (vecValid) begin
            takenAddr <= vecAddr;
            takenNum <= irqNumber;
            taken <= taken + 1;
            irqAck <= 1'b1;
        end else if (irqOut && !vecFetch && !irqAck) begin
            cnt <= cnt + 5'h01;
            vecFetch <= (cnt == {1'b0, slowCycles} + 5'h01);
        end
    end
endmodule

// ===== tb/tb.sv
// bench for hivc_top: registers, priority, pins, mask, wake
// assumes hivc_core_model as core and the bound port checker
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
    logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, usbAct = 0;
    logic        pin0 = 0, pin1 = 0, pready, pslverr, irqOut, irqAck, vecFetch, vecValid;
    logic        wakeUp, er;
    logic [15:0] paddr = 0, vecAddr, tAddr;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [16:0] ev = 0;
    logic [5:0]  irqNumber, tNum;
    logic [3:0]  slow = 0;
    int          taken, wakes, cyc, err_total, checks_done;
    typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic e;} hivc_row_t;
    hivc_row_t rows [13] = '{{1'b0, 16'hC00E, 32'h0, 1'b0}, {1'b0, 16'hC01C, 32'h0, 1'b0},
        {1'b0, 16'hC00A, 32'h0, 1'b0}, {1'b0, 16'hC044, 32'h1FFFF, 1'b0},
        {1'b1, 16'hC00E, 32'hFFFF, 1'b0}, {1'b0, 16'hC00E, 32'h2F, 1'b0},
        {1'b1, 16'hC01C, 32'hFFFF, 1'b0}, {1'b0, 16'hC01C, 32'hF, 1'b0},
        {1'b1, 16'h003E, 32'h5A5A, 1'b0}, {1'b0, 16'h003E, 32'h5A5A, 1'b0},
        {1'b0, 16'h8000, 32'h0, 1'b1}, {1'b1, 16'h8000, 32'h1, 1'b1},
        {1'b0, 16'hC040, 32'h0, 1'b0}};
    hivc_top i_hivc_top (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .timer0Evt(ev[0]), .timer1Evt(ev[1]), .uartTxEvt(ev[4]),
        .uartRxEvt(ev[5]), .dmaDoneEvt(ev[6]), .usbResetEvt(ev[7]), .usbSofToken(ev[8]),
        .epOkEvt({ev[15], ev[13], ev[11], ev[9]}), .epErrEvt({ev[16], ev[14], ev[12], ev[10]}),
        .usbActivity(usbAct), .ext_req0_pin(pin0), .ext_req1_pin(pin1), .irqOut, .irqNumber,
        .irqAck, .vecFetch, .vecAddr, .vecValid, .wakeUp);
    hivc_core_model i_hivc_core_model (.sys_clk, .rst, .irqOut, .irqNumber, .vecValid,
        .vecAddr, .slowCycles(slow), .vecFetch, .irqAck, .takenAddr(tAddr), .takenNum(tNum),
        .taken);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (wakeUp === 1'b1) wakes++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rd)
    endtask
    task automatic fire(input logic [16:0] v, input logic u);
        @(posedge sys_clk);
        ev <= v;
        usbAct <= u;
        @(posedge sys_clk);
        ev <= 17'h0;
        usbAct <= 1'b0;
    endtask
    task automatic pins(input logic p1, input logic p0);
        @(posedge sys_clk);
        pin1 <= p1;
        pin0 <= p0;
    endtask
    task automatic isr(input logic [5:0] n);
        int t0;
        t0 = taken;
        while (taken == t0) @(posedge sys_clk);
        `CHK("number", n, tNum)
        `CHK("vector", 16'h0100 + {n, 1'b0}, tAddr)
    endtask
    task automatic quiet();
        int t0;
        t0 = taken;
        repeat (30) @(posedge sys_clk);
        `CHK("extra", t0, taken)
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : 32'h0);
            if (!rows[i].w) `CHK("reg", rows[i].d, rd)
            `CHK("slverr", rows[i].e, er)
        end
        for (int n = 0; n < 17; n++)
            apb(1'b1, 16'(2 * n), 32'(16'h0100 + 2 * n));
        slow <= 4'h4;
        fire(17'h1FFF3, 1'b0);
        for (int n = 0; n < 17; n++)
            if (n != 2 && n != 3) isr(6'(n));
        slow <= 4'h0;
        pins(1'b0, 1'b1);
        isr(6'd2);
        apb(1'b1, 16'hC01C, 32'h1);
        pins(1'b1, 1'b0);
        isr(6'd2);
        quiet();
        apb(1'b1, 16'hC00A, 32'h30);
        apb(1'b1, 16'hC00E, 32'h2B);
        apb(1'b1, 16'hC01C, 32'hF);
        pins(1'b1, 1'b1);
        quiet();
        `CHK("wake", 1, wakes)
        fire(17'h0, 1'b1);
        apb(1'b1, 16'hC00A, 32'h0);
        fire(17'h0, 1'b1);
        pins(1'b0, 1'b0);
        quiet();
        `CHK("wake", 2, wakes)
        apb(1'b1, 16'hC00E, 32'h28);
        fire(17'h00013, 1'b0);
        isr(6'd4);
        quiet();
        apb(1'b1, 16'hC044, 32'h0);
        fire(17'h00020, 1'b0);
        rdChk(16'hC040, 32'h20);
        `CHK("irq", 1'b0, irqOut)
        apb(1'b1, 16'hC048, 32'h20);
        rdChk(16'hC040, 32'h0);
        fire(17'h00020, 1'b0);
        apb(1'b1, 16'hC044, 32'h1FFFF);
        isr(6'd5);
        report_and_stop();
    end
endmodule
